// [hw/gpm_pkg.sv]
// Package for the general pin port with modem handshake mux.
// Assumes one device clock and a synchronous active-high reset.
package gpm_pkg;

	localparam int GPM_PINS   = 8;
	localparam int GPM_NIBBLE = 4;

	// Register indices on the register port
	localparam logic [1:0] GPM_IDX_DIRECTION = 2'h0;
	localparam logic [1:0] GPM_IDX_LEVEL     = 2'h1;
	localparam logic [1:0] GPM_IDX_IRQ_MASK  = 2'h2;
	localparam logic [1:0] GPM_IDX_FUNC_CTRL = 2'h3;

	// Reset values
	localparam logic [7:0] GPM_RST_DIRECTION = 8'h00;
	localparam logic [7:0] GPM_RST_LEVEL     = 8'h00;
	localparam logic [7:0] GPM_RST_IRQ_MASK  = 8'h00;
	localparam logic [7:0] GPM_RST_FUNC_CTRL = 8'h00;

	// Cycles after reset until synchronised pins are valid
	localparam int GPM_SETTLE_CYCLES = 3;

	// Function control fields
	localparam int GPM_CTRL_CAPTURE_BIT = 0;
	localparam int GPM_CTRL_UPPER_BIT   = 1;
	localparam int GPM_CTRL_LOWER_BIT   = 2;
	localparam int GPM_CTRL_SOFT_RESET_BIT_BIT  = 3;
	localparam logic [7:0] GPM_CTRL_USED_MASK = 8'h0f;

	// Handshake positions within a nibble
	localparam int GPM_NIB_SET_READY = 0;
	localparam int GPM_NIB_TERM_RDY  = 1;
	localparam int GPM_NIB_CARRIER   = 2;
	localparam int GPM_NIB_RING      = 3;

	// Bits taken from the channel's modem registers
	localparam int GPM_IER_MODEM_BIT = 3;
	localparam int GPM_MCR_DTR_BIT   = 0;

	typedef struct packed {
		logic       wr;
		logic       rd;
		logic [1:0] idx;
		logic [7:0] wdata;
	} gpm_reg_req_s;

	typedef struct packed {
		logic carrier;
		logic ring;
		logic set_ready;
		logic d_carrier;
		logic d_ring;
		logic d_set_ready;
		logic irq;
	} gpm_modem_stat_s;

endpackage

// [hw/gpm_sync.sv]
// Two-stage synchroniser for asynchronous pin inputs.
// Assumes pins may change at any time relative to sys_clk_in.
`timescale 1ns/1ps
module gpm_sync #(
	parameter int WIDTH = 8
) (
	input  wire logic             sys_clk_in,
	input  wire logic             rst_in,
	input  wire logic [WIDTH-1:0] async_in,
	output logic      [WIDTH-1:0] sync_out
);
	logic [WIDTH-1:0] meta_ff;

	// First stage is read only by the second stage
	always_ff @(posedge sys_clk_in) begin
		if (rst_in) begin
			meta_ff  <= '0;
			sync_out <= '0;
		end else begin
			meta_ff  <= async_in;
			sync_out <= meta_ff;
		end
	end
endmodule

// [hw/gpm_modem_nibble.sv]
// Modem handshake view of one pin nibble for one serial channel.
// Assumes nibble input is already synchronised to sys_clk_in.
`timescale 1ns/1ps
module gpm_modem_nibble
	import gpm_pkg::*;
(
	input  wire logic            sys_clk_in,
	input  wire logic            rst_in,
	input  wire logic [3:0]      nib_in,
	input  wire logic            modem_role_in,
	input  wire logic            irq_en_in,
	output gpm_modem_stat_s      stat_out
);
	logic [3:0]      prev_ff;
	logic            chg_carrier;
	logic            chg_ring;
	logic            chg_set_ready;
	gpm_modem_stat_s nxt_stat;

	assign chg_carrier   = nib_in[GPM_NIB_CARRIER] ^ prev_ff[GPM_NIB_CARRIER];
	// Ring delta only on a low-to-high pin edge
	assign chg_ring      = nib_in[GPM_NIB_RING] & ~prev_ff[GPM_NIB_RING];
	assign chg_set_ready = nib_in[GPM_NIB_SET_READY]
		^ prev_ff[GPM_NIB_SET_READY];

	always_comb begin
		nxt_stat = '0;
		if (modem_role_in) begin
			nxt_stat.carrier     = ~nib_in[GPM_NIB_CARRIER];
			nxt_stat.ring        = ~nib_in[GPM_NIB_RING];
			nxt_stat.set_ready   = ~nib_in[GPM_NIB_SET_READY];
			nxt_stat.d_carrier   = chg_carrier;
			nxt_stat.d_ring      = chg_ring;
			nxt_stat.d_set_ready = chg_set_ready;
			nxt_stat.irq = irq_en_in
				& (chg_carrier | chg_ring | chg_set_ready);
		end
	end

	always_ff @(posedge sys_clk_in) begin
		if (rst_in) begin
			prev_ff  <= 4'hf;
			stat_out <= '0;
		end else begin
			prev_ff  <= nib_in;
			stat_out <= nxt_stat;
		end
	end
endmodule

// [hw/gpm_port_top.sv]
// General pin port with per-nibble modem handshake role.
// Assumes a simple same-clock register port (one access per strobe)
// and channel modem registers kept by the serial channel logic.
`timescale 1ns/1ps
module gpm_port_top
	import gpm_pkg::*;
#(
	parameter int PINS = GPM_PINS
) (
	input  wire logic             sys_clk_in,
	input  wire logic             srst_in,
	input  wire gpm_reg_req_s     reg_req_in,
	output logic      [7:0]       reg_rdata_out,
	input  wire logic [PINS-1:0]  gpio_in,
	output logic      [PINS-1:0]  gpio_out,
	output logic      [PINS-1:0]  gpio_oe_out,
	input  wire logic [7:0]       irq_enable_reg_a_in,
	input  wire logic [7:0]       irq_enable_reg_b_in,
	input  wire logic [7:0]       modem_ctrl_reg_a_in,
	input  wire logic [7:0]       modem_ctrl_reg_b_in,
	output gpm_modem_stat_s       modem_stat_a_out,
	output gpm_modem_stat_s       modem_stat_b_out,
	output logic                  port_irq_out,
	output logic                  soft_reset_out
);
	logic [PINS-1:0] pin_direction_reg_ff;
	logic [PINS-1:0] pin_level_reg_ff;
	logic [PINS-1:0] pin_change_irq_mask_ff;
	logic [3:0]      pin_function_ctrl_ff;
	logic            soft_reset_bit_ff;
	logic [PINS-1:0] ref_ff;
	logic [PINS-1:0] capture_ff;
	logic [PINS-1:0] pend_ff;

	logic            dev_rst;
	logic [PINS-1:0] pin_sync;
	logic            input_capture_select;
	logic            upper_modem;
	logic            lower_modem;
	logic [PINS-1:0] modem_pins;
	logic [PINS-1:0] watched;
	logic [PINS-1:0] change;
	logic [PINS-1:0] pin_irq;
	logic [PINS-1:0] level_view;
	logic            wr_dir;
	logic            wr_level;
	logic            wr_mask;
	logic            wr_ctrl;
	logic            rd_level;
	logic [7:0]      rd_mux;
	logic [PINS-1:0] nxt_gpio;
	logic [PINS-1:0] nxt_gpio_oe;
	logic [PINS-1:0] nxt_ref;
	logic [PINS-1:0] nxt_capture;
	logic [PINS-1:0] nxt_pend;
	logic            nxt_irq;
	logic            soft_req;
	logic [GPM_SETTLE_CYCLES-1:0] settle_ff;
	logic            settled;
	logic            role_a;
	logic            role_b;

	// One strobe-and-index match for every register
	function automatic logic reg_hit(
		input logic       strobe,
		input logic [1:0] idx,
		input logic [1:0] target
	);
		return strobe & (idx == target);
	endfunction

	// soft reset reaches every register here
	assign dev_rst = srst_in | soft_reset_bit_ff;

	gpm_sync #(
		.WIDTH (PINS)
	) u_sync (
		.sys_clk_in (sys_clk_in),
		.rst_in     (dev_rst),
		.async_in   (gpio_in),
		.sync_out   (pin_sync)
	);

	assign input_capture_select = pin_function_ctrl_ff[GPM_CTRL_CAPTURE_BIT];
	assign upper_modem = pin_function_ctrl_ff[GPM_CTRL_UPPER_BIT];
	assign lower_modem = pin_function_ctrl_ff[GPM_CTRL_LOWER_BIT];
	assign modem_pins  = {{GPM_NIBBLE{upper_modem}},
		{GPM_NIBBLE{lower_modem}}};

	// Register decode
	assign wr_dir   = reg_hit(reg_req_in.wr, reg_req_in.idx,
		GPM_IDX_DIRECTION);
	assign wr_level = reg_hit(reg_req_in.wr, reg_req_in.idx,
		GPM_IDX_LEVEL);
	assign wr_mask  = reg_hit(reg_req_in.wr, reg_req_in.idx,
		GPM_IDX_IRQ_MASK);
	assign wr_ctrl  = reg_hit(reg_req_in.wr, reg_req_in.idx,
		GPM_IDX_FUNC_CTRL);
	assign rd_level = reg_hit(reg_req_in.rd, reg_req_in.idx,
		GPM_IDX_LEVEL);
	assign soft_req = wr_ctrl & reg_req_in.wdata[GPM_CTRL_SOFT_RESET_BIT_BIT];

	// Synchroniser reads zero for two cycles after reset, so
	// change detection waits and the reference follows the pin
	assign settled = ~|settle_ff;
	assign role_a  = upper_modem & settled;
	assign role_b  = lower_modem & settled;

	// modem pins leave the general port
	assign watched = ~pin_direction_reg_ff & ~modem_pins;

	// capture off: change is difference from last read
	// capture on: ref tracks pin so change is an edge
	assign change = (pin_sync ^ ref_ff) & watched & {PINS{settled}};

	always_comb begin
		nxt_ref     = ref_ff;
		nxt_capture = capture_ff;
		nxt_pend    = pend_ff;
		if (input_capture_select) begin
			nxt_ref = pin_sync;
			// read clears, a new change wins
			if (rd_level) begin
				nxt_pend = '0;
			end
			for (int i = 0; i < PINS; i++) begin
				if (change[i] && (!pend_ff[i] || rd_level)) begin
					nxt_capture[i] = pin_sync[i];
					nxt_pend[i]    = 1'b1;
				end
			end
		end else begin
			nxt_pend = '0;
			// read takes the present level as reference
			if (rd_level) begin
				nxt_ref = pin_sync;
			end
			// Unwatched pins keep no stale difference
			nxt_ref = (nxt_ref & watched) | (pin_sync & ~watched);
		end
		// No reference taken from an unfilled synchroniser
		if (!settled) begin
			nxt_ref = pin_sync;
		end
	end

	// capture off: live mismatch, clears itself on revert
	// mask gates, not for modem pins
	assign pin_irq = (input_capture_select ? (pend_ff & watched) : change)
		& pin_change_irq_mask_ff & ~modem_pins;

	assign nxt_irq = |pin_irq;

	// level of every pin, captured bit while pending
	assign level_view = input_capture_select
		? ((capture_ff & pend_ff) | (pin_sync & ~pend_ff))
		: pin_sync;

	always_comb begin
		rd_mux = 8'h00;
		unique case (reg_req_in.idx)
			GPM_IDX_DIRECTION: rd_mux = 8'(pin_direction_reg_ff);
			GPM_IDX_LEVEL:     rd_mux = 8'(level_view);
			GPM_IDX_IRQ_MASK:  rd_mux = 8'(pin_change_irq_mask_ff);
			GPM_IDX_FUNC_CTRL: rd_mux = {4'h0, pin_function_ctrl_ff};
		endcase
	end

	// Pin drive
	always_comb begin
		nxt_gpio    = pin_level_reg_ff;
		nxt_gpio_oe = pin_direction_reg_ff & ~modem_pins;
		// terminal ready follows modem control, active low pin
		if (upper_modem) begin
			nxt_gpio[GPM_NIBBLE + GPM_NIB_TERM_RDY] =
				~modem_ctrl_reg_a_in[GPM_MCR_DTR_BIT];
			nxt_gpio_oe[GPM_NIBBLE + GPM_NIB_TERM_RDY] = 1'b1;
		end
		if (lower_modem) begin
			nxt_gpio[GPM_NIB_TERM_RDY] =
				~modem_ctrl_reg_b_in[GPM_MCR_DTR_BIT];
			nxt_gpio_oe[GPM_NIB_TERM_RDY] = 1'b1;
		end
	end

	// channel A handshakes on upper nibble
	gpm_modem_nibble u_chan_a (
		.sys_clk_in    (sys_clk_in),
		.rst_in        (dev_rst),
		.nib_in        (pin_sync[2*GPM_NIBBLE-1:GPM_NIBBLE]),
		.modem_role_in (role_a),
		.irq_en_in     (irq_enable_reg_a_in[GPM_IER_MODEM_BIT]),
		.stat_out      (modem_stat_a_out)
	);

	// channel B handshakes on lower nibble
	gpm_modem_nibble u_chan_b (
		.sys_clk_in    (sys_clk_in),
		.rst_in        (dev_rst),
		.nib_in        (pin_sync[GPM_NIBBLE-1:0]),
		.modem_role_in (role_b),
		.irq_en_in     (irq_enable_reg_b_in[GPM_IER_MODEM_BIT]),
		.stat_out      (modem_stat_b_out)
	);

	// Registers written by software
	always_ff @(posedge sys_clk_in) begin
		if (dev_rst) begin
			pin_direction_reg_ff   <= PINS'(GPM_RST_DIRECTION);
			pin_level_reg_ff       <= PINS'(GPM_RST_LEVEL);
			pin_change_irq_mask_ff <= PINS'(GPM_RST_IRQ_MASK);
			pin_function_ctrl_ff   <= GPM_RST_FUNC_CTRL[3:0];
		end else begin
			if (wr_dir) begin
				pin_direction_reg_ff <= reg_req_in.wdata[PINS-1:0];
			end
			if (wr_level) begin
				pin_level_reg_ff <= reg_req_in.wdata[PINS-1:0];
			end
			if (wr_mask) begin
				pin_change_irq_mask_ff <= reg_req_in.wdata[PINS-1:0];
			end
			if (wr_ctrl) begin
				pin_function_ctrl_ff <= {1'b0,
					reg_req_in.wdata[2:0] & GPM_CTRL_USED_MASK[2:0]};
			end
		end
	end

	// set by write, cleared by the reset it causes
	always_ff @(posedge sys_clk_in) begin
		if (dev_rst) begin
			soft_reset_bit_ff <= 1'b0;
			soft_reset_out    <= 1'b0;
		end else begin
			soft_reset_bit_ff <= soft_req;
			soft_reset_out    <= soft_req;
		end
	end

	// Settling window restarts with every device reset
	always_ff @(posedge sys_clk_in) begin
		if (dev_rst) begin
			settle_ff <= '1;
		end else begin
			settle_ff <= {settle_ff[GPM_SETTLE_CYCLES-2:0], 1'b0};
		end
	end

	// Change tracking and outputs
	always_ff @(posedge sys_clk_in) begin
		if (dev_rst) begin
			ref_ff        <= '0;
			capture_ff    <= '0;
			pend_ff       <= '0;
			port_irq_out  <= 1'b0;
			gpio_out      <= '0;
			gpio_oe_out   <= '0;
			reg_rdata_out <= 8'h00;
		end else begin
			ref_ff       <= nxt_ref;
			capture_ff   <= nxt_capture;
			pend_ff      <= nxt_pend;
			port_irq_out <= nxt_irq;
			gpio_out     <= nxt_gpio;
			gpio_oe_out  <= nxt_gpio_oe;
			if (reg_req_in.rd) begin
				reg_rdata_out <= rd_mux;
			end
		end
	end
endmodule

// [sim/gpm_pin_partner.sv]
// Pin-side partner: external levels seen on the general pins.
// Assumes the port drives a pin only while its enable is high.
`timescale 1ns/1ps
module gpm_pin_partner (
	input  wire logic [7:0] ext_lvl_in,
	input  wire logic [7:0] pin_drv_in,
	input  wire logic [7:0] pin_oe_in,
	output logic      [7:0] pin_out
);
	// Driven pins read back the port's own level
	assign pin_out = (pin_oe_in & pin_drv_in) | (~pin_oe_in & ext_lvl_in);
endmodule

// [sim/gpm_port_checker.sv]
// Port-level assertions for the pin port, bound into its top module.
// Assumes sys_clk_in is the only clock and srst_in a sync reset.
`timescale 1ns/1ps
module gpm_port_checker
	import gpm_pkg::*;
#(
	parameter int PINS = 8
) (
	input wire logic            sys_clk_in,
	input wire logic            srst_in,
	input wire gpm_reg_req_s    reg_req_in,
	input wire logic [7:0]      reg_rdata_out,
	input wire logic [PINS-1:0] gpio_out,
	input wire logic [PINS-1:0] gpio_oe_out,
	input wire logic [7:0]      modem_ctrl_reg_a_in,
	input wire gpm_modem_stat_s modem_stat_a_out,
	input wire gpm_modem_stat_s modem_stat_b_out,
	input wire logic            port_irq_out,
	input wire logic            soft_reset_out
);
	logic [7:0] dir_ff;
	logic [7:0] mask_ff;
	logic [2:1] role_ff;
	logic [1:0] hold_ff;
	wire        wr_ok = reg_req_in.wr && !soft_reset_out;
	// Shadows reset with the port so that lagged views stay aligned
	always_ff @(posedge sys_clk_in) begin
		hold_ff <= {hold_ff[0], srst_in | soft_reset_out};
		if (srst_in || soft_reset_out) begin
			dir_ff <= 8'h00;
			mask_ff <= 8'h00;
			role_ff <= 2'h0;
		end else if (wr_ok && reg_req_in.idx == GPM_IDX_DIRECTION)
			dir_ff <= reg_req_in.wdata;
		else if (wr_ok && reg_req_in.idx == GPM_IDX_IRQ_MASK)
			mask_ff <= reg_req_in.wdata;
		else if (wr_ok && reg_req_in.idx == GPM_IDX_FUNC_CTRL)
			role_ff <= reg_req_in.wdata[2:1];
	end
	default clocking cb @(posedge sys_clk_in);
	endclocking
	default disable iff (srst_in);
	chk_soft_reset_bit_pulse: assert property (
		wr_ok && reg_req_in.idx == GPM_IDX_FUNC_CTRL
		&& reg_req_in.wdata[3] |=> soft_reset_out)
		else $error("soft reset pulse missing");
	chk_soft_reset_bit_once: assert property (
		soft_reset_out |=> !soft_reset_out)
		else $error("soft reset pulse too long");
	chk_ctrl_rsvd_zero: assert property (
		reg_req_in.rd && !reg_req_in.wr
		&& reg_req_in.idx == GPM_IDX_FUNC_CTRL
		|=> reg_rdata_out[7:3] == 5'h00)
		else $error("control reads nonzero reserved bits");
	chk_stat_a_idle: assert property (
		(!role_ff[1]) [*3] |-> modem_stat_a_out == '0)
		else $error("channel a status active in general role");
	chk_stat_b_idle: assert property (
		(!role_ff[2]) [*3] |-> modem_stat_b_out == '0)
		else $error("channel b status active in general role");
	chk_dtr_drive: assert property (
		role_ff[1] [*3] ##0 $stable(modem_ctrl_reg_a_in)
		|-> gpio_oe_out[5] && gpio_out[5] == !modem_ctrl_reg_a_in[0])
		else $error("terminal ready pin not following control");
	chk_hs_undriven: assert property (
		role_ff[1] [*2] |-> gpio_oe_out[7:6] == 2'h0 && !gpio_oe_out[4])
		else $error("handshake input pin driven");
	chk_dir_oe: assert property (
		!soft_reset_out && hold_ff == 2'h0 && !role_ff[2]
		&& !$past(role_ff[2]) |-> gpio_oe_out[3:0] == $past(dir_ff[3:0]))
		else $error("output enable differs from direction");
	chk_mask_quiet: assert property (
		(mask_ff == 8'h00) [*4] |-> !port_irq_out)
		else $error("pin interrupt with all masks clear");
	chk_carrier_delta_a: assert property (
		role_ff[1] [*5] |-> modem_stat_a_out.d_carrier
		== (modem_stat_a_out.carrier != $past(modem_stat_a_out.carrier)))
		else $error("channel a carrier delta wrong");
	chk_carrier_delta_b: assert property (
		role_ff[2] [*5] |-> modem_stat_b_out.d_carrier
		== (modem_stat_b_out.carrier != $past(modem_stat_b_out.carrier)))
		else $error("channel b carrier delta wrong");
endmodule
bind gpm_port_top gpm_port_checker #(.PINS(PINS)) gpm_port_checker_i (
	.sys_clk_in          (sys_clk_in),
	.srst_in             (srst_in),
	.reg_req_in          (reg_req_in),
	.reg_rdata_out       (reg_rdata_out),
	.gpio_out            (gpio_out),
	.gpio_oe_out         (gpio_oe_out),
	.modem_ctrl_reg_a_in (modem_ctrl_reg_a_in),
	.modem_stat_a_out    (modem_stat_a_out),
	.modem_stat_b_out    (modem_stat_b_out),
	.port_irq_out        (port_irq_out),
	.soft_reset_out      (soft_reset_out)
);

// [sim/tb_top.sv]
// Self-checking bench for the general pin port.
// Assumes the pin partner closes the loop from pin drive to pin level.
`timescale 1ns/1ps
module tb_top
	import gpm_pkg::*;
;
	logic            sys_clk_in = 1'h0;
	logic            srst_in = 1'h1;
	gpm_reg_req_s    req = '0;
	logic [7:0]      ext = 8'h00, irq_enable_reg = 8'h08, modem_ctrl_reg = 8'h01;
	logic [7:0]      rdata, gout, goe, pins;
	gpm_modem_stat_s st_a, st_b;
	logic            irq, sres;
	logic [31:0]     seed = 32'h0000ab95;
	int              err_total = 0, num_checks = 0, sr_cnt = 0;
	always #50 sys_clk_in = ~sys_clk_in;
	always @(negedge sys_clk_in) sr_cnt += sres;
	gpm_port_top #(.PINS(8)) gpm_port_top_i (.sys_clk_in(sys_clk_in),
		.srst_in(srst_in), .reg_req_in(req), .reg_rdata_out(rdata),
		.gpio_in(pins), .gpio_out(gout), .gpio_oe_out(goe),
		.irq_enable_reg_a_in(irq_enable_reg), .irq_enable_reg_b_in(irq_enable_reg),
		.modem_ctrl_reg_a_in(modem_ctrl_reg), .modem_ctrl_reg_b_in(modem_ctrl_reg),
		.modem_stat_a_out(st_a), .modem_stat_b_out(st_b),
		.port_irq_out(irq), .soft_reset_out(sres));
	gpm_pin_partner gpm_pin_partner_i (.ext_lvl_in(ext), .pin_drv_in(gout),
		.pin_oe_in(goe), .pin_out(pins));
	function automatic logic [31:0] xs(input logic [31:0] s);
		s = s ^ (s << 13);
		s = s ^ (s >> 17);
		return s ^ (s << 5);
	endfunction
	// Outputs read back their drive, inputs the outside level
	function automatic logic [7:0] exp_lvl(input logic [7:0] d, v, e);
		return (d & v) | (~d & e);
	endfunction
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		num_checks++;
		if (got !== exp) begin
			err_total++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic cyc(input int n);
		repeat (n) @(negedge sys_clk_in);
	endtask
	task automatic wr(input logic [1:0] i, input logic [7:0] d);
		@(negedge sys_clk_in);
		req = '{wr:1'h1, rd:1'h0, idx:i, wdata:d};
		@(negedge sys_clk_in);
		req.wr = 1'h0;
	endtask
	task automatic rdc(input logic [1:0] i, input logic [7:0] e);
		@(negedge sys_clk_in);
		req = '{wr:1'h0, rd:1'h1, idx:i, wdata:8'h00};
		@(negedge sys_clk_in);
		req.rd = 1'h0;
		chk(rdata, e);
	endtask
	// Collects modem and port interrupts over a bounded window
	task automatic poll(input int c, output logic h, output logic q);
		h = 1'h0;
		q = 1'h0;
		repeat (8) begin
			@(negedge sys_clk_in);
			h = h | (c ? st_b.irq : st_a.irq);
			q = q | irq;
		end
	endtask
	task automatic conclude();
		$display("checks=%0d errors=%0d", num_checks, err_total);
		if (err_total == 0 && num_checks > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	initial begin
		logic [7:0] dir, lv;
		logic       h, q;
		cyc(2);
		srst_in = 1'h0;
		rdc(GPM_IDX_DIRECTION, GPM_RST_DIRECTION);
		rdc(GPM_IDX_FUNC_CTRL, GPM_RST_FUNC_CTRL);
		for (int k = 0; k < 6; k++) begin
			seed = xs(seed);
			{ext, lv, dir} = seed[23:0];
			wr(GPM_IDX_DIRECTION, dir);
			rdc(GPM_IDX_DIRECTION, dir);
			wr(GPM_IDX_IRQ_MASK, seed[31:24]);
			rdc(GPM_IDX_IRQ_MASK, seed[31:24]);
			wr(GPM_IDX_LEVEL, lv);
			cyc(5);
			chk(goe, dir);
			chk(gout & dir, lv & dir);
			rdc(GPM_IDX_LEVEL, exp_lvl(dir, lv, ext));
		end
		wr(GPM_IDX_DIRECTION, 8'h00);
		wr(GPM_IDX_IRQ_MASK, 8'h00);
		ext = 8'h02;
		cyc(6);
		chk(irq, 8'h00);
		wr(GPM_IDX_IRQ_MASK, 8'h01);
		rdc(GPM_IDX_LEVEL, 8'h02);
		ext = 8'h03;
		cyc(5);
		chk(irq, 8'h01);
		ext = 8'h02;
		cyc(5);
		chk(irq, 8'h00);
		ext = 8'h03;
		cyc(5);
		rdc(GPM_IDX_LEVEL, 8'h03);
		cyc(3);
		chk(irq, 8'h00);
		ext = 8'h02;
		cyc(5);
		rdc(GPM_IDX_LEVEL, 8'h02);
		wr(GPM_IDX_FUNC_CTRL, 8'h01);
		ext = 8'h03;
		cyc(5);
		ext = 8'h02;
		cyc(5);
		chk(irq, 8'h01);
		rdc(GPM_IDX_LEVEL, 8'h03);
		cyc(3);
		chk(irq, 8'h00);
		wr(GPM_IDX_FUNC_CTRL, 8'hf0);
		rdc(GPM_IDX_FUNC_CTRL, 8'h00);
		for (int c = 0; c < 2; c++) begin
			int b;
			b = c ? 0 : 4;
			ext = 8'hff;
			irq_enable_reg = 8'h08;
			modem_ctrl_reg = 8'h01;
			wr(GPM_IDX_FUNC_CTRL, c ? 8'h04 : 8'h02);
			wr(GPM_IDX_IRQ_MASK, 8'hff);
			rdc(GPM_IDX_LEVEL, c ? 8'hfd : 8'hdf);
			chk({goe[b+:4], gout[b+1]}, 8'h04);
			modem_ctrl_reg = 8'h00;
			cyc(3);
			chk(gout[b+1], 8'h01);
			ext[b+2] = 1'h0;
			poll(c, h, q);
			chk({h, q}, 8'h02);
			chk(c ? {st_b.carrier, st_b.ring, st_b.set_ready}
				: {st_a.carrier, st_a.ring, st_a.set_ready}, 8'h04);
			irq_enable_reg = 8'h00;
			ext[b+2] = 1'h1;
			poll(c, h, q);
			chk({h, q}, 8'h00);
		end
		wr(GPM_IDX_FUNC_CTRL, 8'h00);
		wr(GPM_IDX_DIRECTION, 8'h5a);
		wr(GPM_IDX_FUNC_CTRL, 8'h08);
		cyc(4);
		chk(sr_cnt[7:0], 8'h01);
		rdc(GPM_IDX_FUNC_CTRL, 8'h00);
		rdc(GPM_IDX_DIRECTION, 8'h00);
		conclude();
	end
endmodule
